// [adc_ctrl_pkg.sv]
// Constants, register map and carrier types of the converter control block
package adc_ctrl_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [2:0] OFF_RES_LOW  = 3'h0;
    localparam logic [2:0] OFF_RES_MID  = 3'h1;
    localparam logic [2:0] OFF_RES_HIGH = 3'h2;
    localparam logic [2:0] OFF_CTL_A    = 3'h3;
    localparam logic [2:0] OFF_CTL_B    = 3'h4;
    localparam logic [2:0] OFF_CLK_SRC  = 3'h5;

    // ************************************************************
    // Field positions, masks and reset values
    // ************************************************************
    localparam int RESTART_BIT  = 7;
    localparam int DOZE_BIT     = 6;
    localparam int PDOWN_BIT    = 5;
    localparam int OSEL_LSB     = 2;
    localparam int REFSEL_BIT   = 0;
    localparam int LAT_BIT      = 7;
    localparam int DIV12_BIT    = 6;
    localparam int HOLD_BIT     = 2;
    localparam int DONE_BIT     = 1;
    localparam logic [7:0] CTL_A_MASK  = 8'hfd;
    localparam logic [7:0] CTL_B_MASK  = 8'hfe;
    localparam logic [7:0] CTL_A_RESET = 8'h20;
    localparam logic [7:0] CTL_B_RESET = 8'h00;
    localparam logic [4:0] CLK_RESET   = 5'h00;
    localparam logic [4:0] CLK_UNDIV   = 5'h1f;

    // ************************************************************
    // Divider and decimation constants
    // ************************************************************
    localparam logic [4:0] ADCK_DIV_SLOW = 5'h1e;  // Divide by 30
    localparam logic [4:0] ADCK_DIV_FAST = 5'h0c;  // Divide by 12
    localparam int         OSR_MAX_LOG   = 14;     // Ratio 16384
    localparam int         RESULT_MSB    = 23;
    localparam logic [23:0] RES_POS_MAX  = 24'h7fffff;
    localparam logic [23:0] RES_NEG_MAX  = 24'h800000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {FILT_IDLE, FILT_RUN} filt_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        logic amp_on;
        logic conv_on;
        logic filt_rst;
        logic ref_ext;
    } power_s;

    typedef struct packed {
        logic [7:0]  ctl_a;
        logic [7:0]  ctl_b;
        logic [4:0]  clk_src;
        logic [23:0] result;
        logic [7:0]  rd_data;
        logic        irq;
        power_s      pwr;
        logic        mclk_tick;
        logic [5:0]  mdiv;
        logic [4:0]  adiv;
        logic        adck_tick;
        filt_e       filt;
        logic [15:0] count;
        logic [15:0] ones;
    } state_s;

endpackage

// [adc_ctrl.sv]
// Control, clocking and result logic of a 24-bit delta-sigma converter
//
// Functional notes
// - Middle result byte read-only, bits 15..8
// - Low result byte read-only, bits 7..0
// - Restart pulse resets filter, starts fresh sequence
// - Doze stops converter, amplifier stays on
// - Power-down resets to 1, overrides all
// - Power-down, then doze, then restart priority
// - Oversample code 0..7 gives 16384 down to 128
// - Averaging two in normal, one in low latency
// - Latency bit picks mode, bit 6 picks divide 30/12
// - Word rate is clock over average times ratio
// - Reference select: internal at 0, external at 1
// - Hold keeps results, blocks done and interrupt
// - Done set by hardware, cleared by software
// - Each conversion end raises interrupt request unless held
// - Results overwrite continuously unless held
// - Source divider: two times code plus two, code 31 undivided
// - Results 24-bit two's complement
// - Out-of-range results saturate, never wrap
// - Unused control bits read as zero, except control B bits 5..3
`timescale 1ns/1ns
module adc_ctrl (
    input  wire logic                   clock,
    input  wire logic                   srst,
    input  wire logic [2:0]             addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    input  wire logic                   mod_bit,
    output logic      [7:0]             rd_data,
    output logic                        conv_irq,
    output logic                        conv_done,
    output logic                        amp_power_on,
    output logic                        conv_power_on,
    output logic                        filter_in_reset,
    output logic                        ref_external,
    output logic                        mclk_tick
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Log2 of the samples in one output word: ratio times averaging
    function automatic logic [3:0] frame_log(input logic [2:0] osel,
                                             input logic       low_lat);
        frame_log = 4'(adc_ctrl_pkg::OSR_MAX_LOG) - {1'b0, osel}
                    + {3'h0, ~low_lat};
    endfunction

    // Scale ones count to a signed 24-bit word with clamping
    function automatic logic [23:0] scale_word(input logic [15:0] ones,
                                               input logic [3:0]  lg);
        logic signed [31:0] diff;
        logic signed [31:0] wide;
        diff = $signed({15'h0, ones, 1'b0})
               - $signed(32'h1 << lg);
        wide = diff <<< (5'(adc_ctrl_pkg::RESULT_MSB) - {1'b0, lg});
        if (wide > $signed({8'h0, adc_ctrl_pkg::RES_POS_MAX})) begin
            scale_word = adc_ctrl_pkg::RES_POS_MAX;
        end else if (wide < -$signed({8'h0, adc_ctrl_pkg::RES_NEG_MAX})) begin
            scale_word = adc_ctrl_pkg::RES_NEG_MAX;
        end else begin
            scale_word = wide[23:0];
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    adc_ctrl_pkg::bus_req_s req;
    adc_ctrl_pkg::state_s   s_q;
    adc_ctrl_pkg::state_s   s_d;
    logic [3:0]             lg;
    logic [15:0]            last;
    logic [15:0]            ones_nx;
    logic                   running;
    logic                   held;
    logic                   word_end;
    logic [4:0]             adck_div;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Mode and field decode from the stored control registers
    assign lg = frame_log(s_q.ctl_a[adc_ctrl_pkg::OSEL_LSB +: 3],
                          s_q.ctl_b[adc_ctrl_pkg::LAT_BIT]);
    assign last    = 16'((32'h1 << lg) - 32'h1);
    assign running = ~s_q.ctl_a[adc_ctrl_pkg::PDOWN_BIT]
                   & ~s_q.ctl_a[adc_ctrl_pkg::DOZE_BIT]
                   & ~s_q.ctl_a[adc_ctrl_pkg::RESTART_BIT];
    assign held    = s_q.ctl_b[adc_ctrl_pkg::HOLD_BIT];
    assign ones_nx = s_q.ones + {15'h0, mod_bit};
    assign word_end = s_q.adck_tick && (s_q.filt == adc_ctrl_pkg::FILT_RUN)
                      && (s_q.count == last);
    assign adck_div = s_q.ctl_b[adc_ctrl_pkg::DIV12_BIT]
                    ? adc_ctrl_pkg::ADCK_DIV_FAST
                    : adc_ctrl_pkg::ADCK_DIV_SLOW;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rd_data = 8'h00;
        s_d.irq     = 1'b0;

        // Register writes; reserved bits are masked off, except control B bits 5..3
        if (req.wr) begin
            case (req.addr)
                adc_ctrl_pkg::OFF_CTL_A: begin
                    s_d.ctl_a = req.wdata & adc_ctrl_pkg::CTL_A_MASK;
                end
                adc_ctrl_pkg::OFF_CTL_B: begin
                    s_d.ctl_b = req.wdata & adc_ctrl_pkg::CTL_B_MASK;
                end
                adc_ctrl_pkg::OFF_CLK_SRC: begin
                    s_d.clk_src = req.wdata[4:0];
                end
                default: begin
                    s_d.clk_src = s_q.clk_src;      // Results are read-only
                end
            endcase
        end

        // Register reads, answered in the next cycle only
        if (req.rd) begin
            case (req.addr)
                adc_ctrl_pkg::OFF_RES_LOW:  s_d.rd_data = s_q.result[7:0];
                adc_ctrl_pkg::OFF_RES_MID:  s_d.rd_data = s_q.result[15:8];
                adc_ctrl_pkg::OFF_RES_HIGH: s_d.rd_data = s_q.result[23:16];
                adc_ctrl_pkg::OFF_CTL_A:    s_d.rd_data = s_q.ctl_a;
                adc_ctrl_pkg::OFF_CTL_B:    s_d.rd_data = s_q.ctl_b;
                adc_ctrl_pkg::OFF_CLK_SRC:  s_d.rd_data = {3'h0, s_q.clk_src};
                default:                    s_d.rd_data = 8'h00;
            endcase
        end

        // Power and reference outputs from the mode bits
        s_d.pwr.amp_on   = ~s_q.ctl_a[adc_ctrl_pkg::PDOWN_BIT];
        s_d.pwr.conv_on  = ~s_q.ctl_a[adc_ctrl_pkg::PDOWN_BIT]
                         & ~s_q.ctl_a[adc_ctrl_pkg::DOZE_BIT];
        s_d.pwr.filt_rst = ~running;
        s_d.pwr.ref_ext  = s_q.ctl_a[adc_ctrl_pkg::REFSEL_BIT];

        // Master clock: system clock over 2*(code+1), or undivided
        s_d.mclk_tick = 1'b0;
        if (s_q.clk_src == adc_ctrl_pkg::CLK_UNDIV) begin
            s_d.mclk_tick = 1'b1;
            s_d.mdiv      = 6'h00;
        end else if (s_q.mdiv >= {s_q.clk_src, 1'b1}) begin
            s_d.mclk_tick = 1'b1;
            s_d.mdiv      = 6'h00;
        end else begin
            s_d.mdiv = s_q.mdiv + 6'h01;
        end

        // Converter clock: master clock over 30 or 12
        s_d.adck_tick = 1'b0;
        if (!s_q.pwr.conv_on) begin
            s_d.adiv = 5'h00;
        end else if (s_q.mclk_tick) begin
            if (s_q.adiv >= adck_div - 5'h01) begin
                s_d.adiv      = 5'h00;
                s_d.adck_tick = 1'b1;
            end else begin
                s_d.adiv = s_q.adiv + 5'h01;
            end
        end

        // Decimation filter: count ones over one output word
        case (s_q.filt)
            adc_ctrl_pkg::FILT_IDLE: begin
                s_d.count = 16'h0000;
                s_d.ones  = 16'h0000;
                if (running) begin
                    s_d.filt = adc_ctrl_pkg::FILT_RUN;
                end
            end
            adc_ctrl_pkg::FILT_RUN: begin
                if (!running) begin
                    s_d.filt = adc_ctrl_pkg::FILT_IDLE;
                end else if (word_end) begin
                    s_d.count = 16'h0000;
                    s_d.ones  = 16'h0000;
                    if (!held) begin
                        s_d.result = scale_word(ones_nx, lg);
                        s_d.irq    = 1'b1;
                    end
                end else if (s_q.adck_tick) begin
                    s_d.count = s_q.count + 16'h0001;
                    s_d.ones  = ones_nx;
                end
            end
            default: begin
                s_d.filt = adc_ctrl_pkg::FILT_IDLE;
            end
        endcase

        // Done flag: a new word wins over a software clear
        if (running && word_end && !held) begin
            s_d.ctl_b[adc_ctrl_pkg::DONE_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q           <= '0;
            s_q.ctl_a     <= adc_ctrl_pkg::CTL_A_RESET;
            s_q.ctl_b     <= adc_ctrl_pkg::CTL_B_RESET;
            s_q.clk_src   <= adc_ctrl_pkg::CLK_RESET;
            s_q.filt      <= adc_ctrl_pkg::FILT_IDLE;
            s_q.pwr.filt_rst <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data         = s_q.rd_data;
    assign conv_irq        = s_q.irq;
    assign conv_done       = s_q.ctl_b[adc_ctrl_pkg::DONE_BIT];
    assign amp_power_on    = s_q.pwr.amp_on;
    assign conv_power_on   = s_q.pwr.conv_on;
    assign filter_in_reset = s_q.pwr.filt_rst;
    assign ref_external    = s_q.pwr.ref_ext;
    assign mclk_tick       = s_q.mclk_tick;

endmodule

// [adc_ctrl_monitor.sv]
// Port-level checker of the converter control block
`timescale 1ns/1ns
module adc_ctrl_monitor (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       mod_bit,
    input wire logic [7:0] rd_data,
    input wire logic       conv_irq,
    input wire logic       conv_done,
    input wire logic       amp_power_on,
    input wire logic       conv_power_on,
    input wire logic       filter_in_reset,
    input wire logic       ref_external,
    input wire logic       mclk_tick
);
    // ************************************************************
    // Helper terms and sequences
    // ************************************************************
    wire ctl_wr = wr && (addr == adc_ctrl_pkg::OFF_CTL_A);
    wire clr_done = wr && (addr == adc_ctrl_pkg::OFF_CTL_B) && !wdata[1];
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_doze_wr; ctl_wr && !wdata[5] && wdata[6]; endsequence
    sequence s_rst_wr; ctl_wr && wdata[7:5] == 3'h4; endsequence

    // Register, power and result relations
    property p_unmapped; rd && addr > 3'h5 |=> rd_data == 8'h00; endproperty
    property p_irq_pulse; conv_irq |=> !conv_irq; endproperty
    property p_irq_done; conv_irq |-> conv_done; endproperty
    property p_done_sw;
        $fell(conv_done) |-> $past(clr_done) || $past(clr_done, 2);
    endproperty
    property p_pdown;
        ctl_wr && wdata[5] |-> ##2 !amp_power_on && filter_in_reset;
    endproperty
    property p_doze; s_doze_wr |-> ##2 amp_power_on && !conv_power_on;
    endproperty
    property p_restart; s_rst_wr |-> ##2 conv_power_on && filter_in_reset;
    endproperty
    property p_ref; ctl_wr |-> ##2 ref_external == $past(wdata[0], 2);
    endproperty
    property p_irq_run; conv_irq |-> conv_power_on && !filter_in_reset;
    endproperty
    property p_order; conv_power_on |-> amp_power_on; endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad idle read");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq long");
    a_irq_done: assert property (p_irq_done) else $error("no done");
    a_done_sw: assert property (p_done_sw) else $error("done lost");
    a_pdown: assert property (p_pdown) else $error("power-down");
    a_doze: assert property (p_doze) else $error("doze");
    a_restart: assert property (p_restart) else $error("restart");
    a_ref: assert property (p_ref) else $error("reference");
    a_irq_run: assert property (p_irq_run) else $error("irq idle");
    a_order: assert property (p_order) else $error("power order");
endmodule

bind adc_ctrl adc_ctrl_monitor mon (.clock(clock), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .mod_bit(mod_bit),
    .rd_data(rd_data), .conv_irq(conv_irq), .conv_done(conv_done),
    .amp_power_on(amp_power_on), .conv_power_on(conv_power_on),
    .filter_in_reset(filter_in_reset), .ref_external(ref_external),
    .mclk_tick(mclk_tick));

// [adc_ctrl_bench.sv]
// Self-checking bench of the converter control block
`timescale 1ns/1ns
module adc_ctrl_bench;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        mod_bit = 1'b0;
    logic [7:0]  rd_data, v, d;
    logic        conv_irq, conv_done, amp_power_on, conv_power_on;
    logic        filter_in_reset, ref_external, mclk_tick;
    logic [1:0]  tk;
    logic [23:0] word;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          seed = 80374;
    int          n, p;
    logic [7:0]  cb [5] = '{8'hc0, 8'h40, 8'h80, 8'hc0, 8'hc0};
    logic [4:0]  ck [5] = '{5'h1f, 5'h1f, 5'h1f, 5'h00, 5'h1f};
    logic [2:0]  os [5] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h6};
    logic [7:0]  ma [3] = '{8'h9c, 8'h5c, 8'h3c};

    adc_ctrl uut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .mod_bit(mod_bit), .rd_data(rd_data),
        .conv_irq(conv_irq), .conv_done(conv_done),
        .amp_power_on(amp_power_on), .conv_power_on(conv_power_on),
        .filter_in_reset(filter_in_reset), .ref_external(ref_external),
        .mclk_tick(mclk_tick));

    // ************************************************************
    // Clock, timeout and helpers
    // ************************************************************
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [23:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] x);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, output logic [7:0] x);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 x = rd_data;
    endtask
    task automatic wait_irq(input int lim, output int k);
        k = 0;
        do begin
            @(posedge clock);
            #1 k++;
        end while (k < lim && conv_irq !== 1'b1);
    endtask
    // Power outputs expected from a control_a value
    function automatic logic [3:0] pwr(input logic [7:0] x);
        return {~x[5], ~x[5] & ~x[6], x[5] | x[6] | x[7], x[0]};
    endfunction
    // System cycles per output word
    function automatic int period(input logic [7:0] b, input logic [4:0] c,
                                  input logic [2:0] o);
        return (c == 5'h1f ? 1 : 2 * (int'(c) + 1)) * (b[6] ? 12 : 30)
            * (b[7] ? 1 : 2) * (1 << (14 - int'(o)));
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        rreg(adc_ctrl_pkg::OFF_CTL_A, v);
        chk("ctl_a reset", v, 8'h20);
        rreg(adc_ctrl_pkg::OFF_CTL_B, v);
        chk("ctl_b reset", v, 8'h00);
        chk("reset power", {amp_power_on, conv_power_on, filter_in_reset,
            ref_external}, 4'h2);
        // Random register traffic with the filter held in reset
        repeat (8) begin
            d = $random(seed) | 8'h80;
            wreg(adc_ctrl_pkg::OFF_CTL_A, d);
            @(posedge clock);
            #1 chk("power", {amp_power_on, conv_power_on, filter_in_reset,
                ref_external}, pwr(d));
            rreg(adc_ctrl_pkg::OFF_CTL_A, v);
            chk("ctl_a", v, d & adc_ctrl_pkg::CTL_A_MASK);
            wreg(adc_ctrl_pkg::OFF_CTL_B, d);
            rreg(adc_ctrl_pkg::OFF_CTL_B, v);
            chk("ctl_b", v, d & adc_ctrl_pkg::CTL_B_MASK);
            wreg(adc_ctrl_pkg::OFF_CLK_SRC, d);
            rreg(adc_ctrl_pkg::OFF_CLK_SRC, v);
            chk("clk_src", v, d & 8'h1f);
            rreg(3'h6 | 3'($random(seed) & 1), v);
            chk("unmapped", v, 8'h00);
        end
        // Conversion modes, word rate, saturation and hold
        for (int i = 0; i < 5; i++) begin
            mod_bit <= 1'($random(seed));
            p = period(cb[i], ck[i], os[i]);
            wreg(adc_ctrl_pkg::OFF_CLK_SRC, 8'(ck[i]));
            wreg(adc_ctrl_pkg::OFF_CTL_B, cb[i]);
            wreg(adc_ctrl_pkg::OFF_CTL_A, {3'h4, os[i], 2'h0});
            wreg(adc_ctrl_pkg::OFF_CTL_A, {3'h0, os[i], 2'h0});
            // Undivided source ticks every cycle, code 0 every other one
            @(posedge clock);
            #1 tk[0] = mclk_tick;
            @(posedge clock);
            #1 tk[1] = mclk_tick;
            chk("master tick", ck[i] == 5'h1f ? tk : {1'b0, ^tk},
                ck[i] == 5'h1f ? 2'h3 : 2'h1);
            wait_irq(9000, n);
            chk("done", conv_done, 1'b1);
            wait_irq(9000, n);
            chk("word gap", n, p);
            wreg(adc_ctrl_pkg::OFF_CTL_B, cb[i] | 8'h04);
            rreg(adc_ctrl_pkg::OFF_RES_HIGH, word[23:16]);
            rreg(adc_ctrl_pkg::OFF_RES_MID, word[15:8]);
            rreg(adc_ctrl_pkg::OFF_RES_LOW, word[7:0]);
            chk("result", word,
                mod_bit ? 24'h7fffff : 24'h800000);
            chk("done clear", conv_done, 1'b0);
            wait_irq(p + 50, n);
            chk("held", {conv_done, 1'(n == p + 50)}, 2'h1);
            wreg(adc_ctrl_pkg::OFF_CTL_B, cb[i]);
        end
        // Restart held, doze and power-down stop the words
        for (int i = 0; i < 3; i++) begin
            wreg(adc_ctrl_pkg::OFF_CTL_A, ma[i]);
            @(posedge clock);
            #1 chk("mode", {amp_power_on, conv_power_on, filter_in_reset,
                ref_external}, pwr(ma[i]));
            wait_irq(3200, n);
            chk("no word", n, 3200);
        end
        wreg(adc_ctrl_pkg::OFF_CTL_A, 8'h18);
        wait_irq(3200, n);
        chk("restarted", 1'(n < 3200), 1'b1);
        finish_test();
    end
endmodule
